// ==== cmr_bus_model.sv ====
// Purpose: far-side bit source for the transmit pins
// Assumes: eight clocks a bit, a quantum every two clocks
// Notes:   ticks stop and the stream rests recessive outside frames
`timescale 1ns/1ps
module cmr_bus_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic run_i,
  output logic      tx_bit_o,
  output logic      bit_start_o,
  output logic      tq_tick_o,
  output logic      ack_slot_o
);
  logic [2:0] ph_reg;  // clock within the bit
  logic [7:0] pat_reg; // bit pattern, rotated once a bit
  always_ff @(posedge clk_i) begin
    if (!rst_n_i || !run_i) begin
      ph_reg  <= 3'h0;
      pat_reg <= 8'h9b;
    end else begin
      ph_reg <= ph_reg + 3'h1;
      if (ph_reg == 3'h7) pat_reg <= {pat_reg[6:0], pat_reg[7]};
    end
  end
  assign bit_start_o = run_i && (ph_reg == 3'h0);
  assign tq_tick_o   = run_i && ph_reg[0];
  assign tx_bit_o    = !run_i || pat_reg[7];
  assign ack_slot_o  = run_i && pat_reg[0]; // stands in for the ack bit
endmodule

// ==== cmr_monitor.sv ====
// Purpose: port checks of the mode, driver and rx window block
// Assumes: one clock, synchronous active-low reset
// Notes:   bound onto cmr_top from the bench top file
`timescale 1ns/1ps
module cmr_monitor
  import cmr_pkg::*;
#(parameter int RX_DEPTH = 4) (
  input wire logic        CLOCK_I, RST_N_I, CYC_I, STB_I, WE_I, ACK_O,
  input wire logic [6:2]  ADR_I,
  input wire logic [3:0]  SEL_I,
  input wire logic [31:0] DAT_I, DAT_O,
  input wire logic        IRQ_PENDING_I, BUS_IDLE_I, RX_VALID_I, RX_READY_O,
  input wire logic        ACK_SLOT_I, TX_DONE_I, ACK_SEEN_I, RESET_MODE_O, ABORT_O,
  input wire logic        SLEEPING_O, SELF_CHECK_O, PASSIVE_MONITOR_O, TX_SUCCESS_O,
  input wire logic [4:0]  MSG_COUNT_O,
  input wire logic        TX_PIN_FIRST_O
);
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RST_N_I);
  wire wr_take = ACK_O && WE_I && SEL_I[0]; // write lands at this edge
  wire rd_take = ACK_O && !WE_I;            // read data valid now
  ack_single_a: assert property (ACK_O |=> !ACK_O) else $error("ack held");
  ack_answer_a: assert property (CYC_I && STB_I && !ACK_O |=> ACK_O) else $error("no ack");
  mode_zero_a: assert property (rd_take && ADR_I == IDX_MODE |-> DAT_O[7:5] == 3'h0)
    else $error("mode top bits set");
  win_reset_a: assert property (rd_take && RESET_MODE_O && ADR_I >= IDX_WIN_LO
    && ADR_I <= IDX_WIN_HI |-> DAT_O == 32'h0) else $error("window read in reset");
  halt_track_a: assert property (wr_take && ADR_I == IDX_MODE
    |=> RESET_MODE_O == $past(DAT_I[0])) else $error("halt bit not followed");
  abort_mode_a: assert property (ABORT_O |-> RESET_MODE_O) else $error("abort outside reset");
  sleep_gate_a: assert property ($rose(SLEEPING_O)
    |-> !$past(IRQ_PENDING_I) && $past(BUS_IDLE_I)) else $error("slept while busy");
  tx_result_a: assert property (TX_DONE_I && !RESET_MODE_O
    |=> TX_SUCCESS_O == ($past(ACK_SEEN_I) || $past(SELF_CHECK_O))) else $error("tx result");
  ack_silent_a: assert property ($past(PASSIVE_MONITOR_O) && $past(ACK_SLOT_I)
    |-> TX_PIN_FIRST_O) else $error("ack driven while monitoring");
  count_up_a: assert property (RX_VALID_I && RX_READY_O && !wr_take
    |=> MSG_COUNT_O == $past(MSG_COUNT_O) + 5'h1) else $error("count not raised");
endmodule

// ==== cmr_pkg.sv ====
// Purpose: shared constants and types for the CAN mode, output and rx window block
// Assumes: byte-wide registers, each in the low lane of one 32-bit Wishbone word
// Notes:   register index is the printed offset; byte address is four times it
package cmr_pkg;

  // controller clock
  localparam int unsigned CLK_HZ = 25_000_000;

  ////////////////////////////////////////////////////////////////////////////
  // register indices (word address = index)
  localparam logic [4:0] IDX_MODE   = 5'h00;
  localparam logic [4:0] IDX_CMD    = 5'h01;
  localparam logic [4:0] IDX_OCR    = 5'h08;
  localparam logic [4:0] IDX_WIN_LO = 5'h10;
  localparam logic [4:0] IDX_WIN_HI = 5'h1c;
  localparam logic [4:0] IDX_COUNT  = 5'h1d;

  ////////////////////////////////////////////////////////////////////////////
  // operating configuration fields
  localparam int MODE_HALT    = 0;
  localparam int MODE_PASSIVE = 1;
  localparam int MODE_SELF    = 2;
  localparam int MODE_FILTER  = 3;
  localparam int MODE_SLEEP   = 4;
  localparam logic [7:0] MODE_RESET = 8'h01;

  // command register: release receive buffer
  localparam int CMD_RELEASE = 2;

  // transmit driver config fields
  localparam int OCR_LOWER = 0;
  localparam int OCR_UPPER = 1;
  localparam logic [1:0] OCR_RESET = 2'h2;

  ////////////////////////////////////////////////////////////////////////////
  // receive window layout
  localparam int WIN_BYTES  = 13;
  localparam int INFO_EXT   = 7;
  localparam int INFO_REM   = 6;
  localparam logic [3:0] SFF_UNUSED_A = 4'hb;
  localparam logic [3:0] SFF_UNUSED_B = 4'hc;
  localparam int CNT_W = 5;

  // one received frame, byte 0 is the frame descriptor
  typedef logic [WIN_BYTES-1:0][7:0] cmr_frame_t;

  // output driver configuration
  typedef enum logic [1:0] {
    DRV_RESV  = 2'b00,
    DRV_NORM  = 2'b01,
    DRV_CLOCK = 2'b10
  } cmr_drv_t;

  // power state
  typedef enum logic {
    PWR_RUN   = 1'b0,
    PWR_SLEEP = 1'b1
  } cmr_pwr_t;

endpackage

// ==== cmr_top.sv ====
// Purpose: mode register, output driver config and receive window of a CAN node
// Assumes: bit processor and acceptance filters sit outside and use the outputs
// Notes:   one clock, synchronous active-low reset, Wishbone classic slave
//
// What this block does
// - top three config bits read zero
// - sleep only if idle, else wake up
// - sleep bit written only in operating mode
// - clearing sleep bit wakes the node
// - filter bit picks single or dual filter
// - self check makes unacked transmission succeed
// - passive monitor never drives acknowledge
// - halt bit aborts frame, enters reset mode
// - operating mode resumes on halt falling
// - normal output: stream and its inverse
// - clock output: stream plus bit clock
// - output mode bits decode reserved/normal/clock
// - driver config writable in reset mode only
// - thirteen byte window shows oldest frame
// - window readable in operating mode only
// - first byte is frame descriptor
// - standard frame: two id, eight data
// - extended frame: four id, eight data
// - count frames: receive adds, release subtracts
`timescale 1ns/1ps

module cmr_top #(
  parameter int RX_DEPTH = 4 // frames held in the receive fifo
) (
  // clock and reset
  input  wire logic                CLOCK_I,
  input  wire logic                RST_N_I,
  // wishbone classic slave
  input  wire logic                CYC_I,
  input  wire logic                STB_I,
  input  wire logic                WE_I,
  input  wire logic [6:2]          ADR_I,
  input  wire logic [3:0]          SEL_I,
  input  wire logic [31:0]         DAT_I,
  output logic      [31:0]         DAT_O,
  output logic                     ACK_O,
  // status from the rest of the controller
  input  wire logic                IRQ_PENDING_I,
  input  wire logic                BUS_IDLE_I,
  // received frames from the bit processor
  input  wire logic                RX_VALID_I,
  input  wire cmr_pkg::cmr_frame_t RX_FRAME_I,
  output logic                     RX_READY_O,
  // transmit path from the bit processor
  input  wire logic                TX_BIT_I,
  input  wire logic                ACK_SLOT_I,
  input  wire logic                BIT_START_I,
  input  wire logic                TQ_TICK_I,
  input  wire logic                TX_DONE_I,
  input  wire logic                ACK_SEEN_I,
  // mode outputs to the controller
  output logic                     RESET_MODE_O,
  output logic                     ABORT_O,
  output logic                     SLEEPING_O,
  output logic                     WAKEUP_O,
  output logic                     FILTER_SINGLE_O,
  output logic                     SELF_CHECK_O,
  output logic                     PASSIVE_MONITOR_O,
  output logic                     TX_SUCCESS_O,
  output logic [4:0]               MSG_COUNT_O,
  // bus pins
  output logic                     TX_PIN_FIRST_O,
  output logic                     TX_PIN_SECOND_O
);
  import cmr_pkg::*;

  localparam int PW = (RX_DEPTH > 1) ? $clog2(RX_DEPTH) : 1;
  localparam logic [PW-1:0] PTR_LAST = PW'(RX_DEPTH - 1);
  localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(RX_DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // all state of the block except the fifo storage
  typedef struct packed {
    logic             ack;        // bus acknowledge
    logic [7:0]       dat;        // read data byte
    cmr_pwr_t         pwr;        // sleep state, doubles as the sleep bit
    logic             filt;       // single filter select
    logic             self_chk;   // self check enable
    logic             passive;    // passive monitor enable
    logic             halt;       // reset mode bit
    logic [1:0]       drv;        // output mode bits
    logic [CNT_W-1:0] count;      // pending message count
    logic [PW-1:0]    wr;         // fifo write slot
    logic [PW-1:0]    rd;         // fifo read slot (oldest frame)
    logic             abort;      // abort pulse
    logic             wake;       // wake-up pulse
    logic             tx_ok;      // transmission success pulse
    logic             bitclk;     // bit period clock level
    logic             pin0;       // first transmit pin
    logic             pin1;       // second transmit pin
  } cmr_state_t;

  cmr_state_t st_reg;             // registered state
  cmr_state_t st_next;            // next state

  cmr_frame_t fifo_mem [RX_DEPTH]; // receive fifo storage

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // window index check, used by the read decode
  function automatic logic in_window(input logic [4:0] idx);
    in_window = (idx >= IDX_WIN_LO) && (idx <= IDX_WIN_HI);
  endfunction

  // output mode decode
  function automatic cmr_drv_t drv_decode(input logic [1:0] bits);
    if (!bits[OCR_UPPER]) begin
      drv_decode = DRV_RESV;
    end else if (bits[OCR_LOWER]) begin
      drv_decode = DRV_CLOCK;
    end else begin
      drv_decode = DRV_NORM;
    end
  endfunction

  // ring pointer step, works for depths that are not powers of two
  function automatic logic [PW-1:0] ptr_step(input logic [PW-1:0] p);
    ptr_step = (p == PTR_LAST) ? '0 : p + 1'b1;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // combinational decode

  logic       req;        // a bus cycle is open
  logic       wr_hit;     // write takes effect at this edge
  logic [4:0] idx;        // register index
  logic [3:0] woff;       // byte within the window
  logic       push;       // frame accepted this cycle
  logic       pop;        // release command accepted
  logic       serial;     // stream after acknowledge masking
  logic [7:0] rdata;      // read data before the register
  cmr_frame_t head;       // oldest frame
  cmr_drv_t   drv_mode;   // decoded driver mode

  assign req      = CYC_I && STB_I;
  assign wr_hit   = req && st_reg.ack && WE_I && SEL_I[0];
  assign idx      = ADR_I;
  assign woff     = 4'(idx - IDX_WIN_LO);
  assign head     = fifo_mem[st_reg.rd];
  assign drv_mode = drv_decode(st_reg.drv);

  // frames are taken only in operating mode and while a slot is free
  assign RX_READY_O = !st_reg.halt && (st_reg.count < CNT_FULL);
  assign push       = RX_VALID_I && RX_READY_O;

  // release pops the oldest frame when one is held
  assign pop = wr_hit && (idx == IDX_CMD) && DAT_I[CMD_RELEASE] &&
               !st_reg.halt && (st_reg.count != '0);

  // ack slot masked to recessive in passive monitor mode
  assign serial = (st_reg.passive && ACK_SLOT_I) ? 1'b1 : TX_BIT_I;

  ////////////////////////////////////////////////////////////////////////////
  // read data mux
  always_comb begin
    rdata = 8'h00;
    if (idx == IDX_MODE) begin
      // reserved bits stay zero
      rdata[MODE_SLEEP]   = (st_reg.pwr == PWR_SLEEP);
      rdata[MODE_FILTER]  = st_reg.filt;
      rdata[MODE_SELF]    = st_reg.self_chk;
      rdata[MODE_PASSIVE] = st_reg.passive;
      rdata[MODE_HALT]    = st_reg.halt;
    end else if (idx == IDX_OCR) begin
      rdata[1:0] = st_reg.drv;
    end else if (idx == IDX_COUNT) begin
      rdata[CNT_W-1:0] = st_reg.count;
    end else if (in_window(idx) && !st_reg.halt && (st_reg.count != '0)) begin
      // descriptor at byte 0, ids and data follow
      rdata = head[woff];
      if (!head[0][INFO_EXT] &&
          ((woff == SFF_UNUSED_A) || (woff == SFF_UNUSED_B))) begin
        rdata = 8'h00;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    st_next       = st_reg;
    st_next.abort = 1'b0;
    st_next.wake  = 1'b0;

    // single-cycle ack, dropped the cycle after it was given
    st_next.ack = req && !st_reg.ack;
    if (req && !st_reg.ack) begin
      st_next.dat = rdata;
    end

    // operating configuration write
    if (wr_hit && (idx == IDX_MODE)) begin
      st_next.filt    = DAT_I[MODE_FILTER];
      st_next.self_chk = DAT_I[MODE_SELF];
      st_next.passive = DAT_I[MODE_PASSIVE];
      st_next.halt    = DAT_I[MODE_HALT];
      if (DAT_I[MODE_HALT] && !st_reg.halt) begin
        st_next.abort = 1'b1;
      end
      // sleep field honoured only when the node was operating
      if (!st_reg.halt) begin
        if (DAT_I[MODE_SLEEP]) begin
          if (!IRQ_PENDING_I && BUS_IDLE_I) begin
            st_next.pwr = PWR_SLEEP;
          end else begin
            st_next.pwr  = PWR_RUN;
            st_next.wake = 1'b1;
          end
        end else begin
          st_next.pwr = PWR_RUN;
          if (st_reg.pwr == PWR_SLEEP) begin
            st_next.wake = 1'b1;
          end
        end
      end
    end else if ((st_reg.pwr == PWR_SLEEP) && !BUS_IDLE_I) begin
      // bus activity ends sleep as well
      st_next.pwr  = PWR_RUN;
      st_next.wake = 1'b1;
    end

    // driver config is frozen outside reset mode
    if (wr_hit && (idx == IDX_OCR) && st_reg.halt) begin
      st_next.drv = DAT_I[1:0];
    end

    // window writes fall through: nothing is stored

    // message count and fifo pointers
    if (push) begin
      st_next.wr = ptr_step(st_reg.wr);
    end
    if (pop) begin
      st_next.rd = ptr_step(st_reg.rd);
    end
    case ({push, pop})
      2'b10:   st_next.count = st_reg.count + 1'b1;
      2'b01:   st_next.count = st_reg.count - 1'b1;
      default: st_next.count = st_reg.count;
    endcase
    // entering reset mode drops held messages, data stays in place
    if (st_next.abort) begin
      st_next.count = '0;
      st_next.wr    = st_reg.rd;
    end

    // success needs an acknowledge unless self check is on
    st_next.tx_ok = TX_DONE_I && (ACK_SEEN_I || st_reg.self_chk);

    // bit clock: rises at bit start, falls after one time quantum
    if (BIT_START_I) begin
      st_next.bitclk = 1'b1;
    end else if (TQ_TICK_I) begin
      st_next.bitclk = 1'b0;
    end

    // pin drive per output mode
    case (drv_mode)
      DRV_NORM: begin
        st_next.pin0 = serial;
        st_next.pin1 = !serial;
      end
      DRV_CLOCK: begin
        st_next.pin0 = serial;
        st_next.pin1 = st_next.bitclk;
      end
      default: begin
        // reserved mode keeps the pins recessive and quiet
        st_next.pin0 = 1'b1;
        st_next.pin1 = 1'b0;
      end
    endcase

    // no transmission success is flagged in reset mode; the pins keep following the stream
    if (st_reg.halt) begin
      st_next.tx_ok = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge CLOCK_I) begin
    if (!RST_N_I) begin
      st_reg          <= '0;
      st_reg.pwr      <= PWR_RUN;
      st_reg.halt     <= MODE_RESET[MODE_HALT];
      st_reg.filt     <= MODE_RESET[MODE_FILTER];
      st_reg.self_chk <= MODE_RESET[MODE_SELF];
      st_reg.passive  <= MODE_RESET[MODE_PASSIVE];
      st_reg.drv      <= OCR_RESET;
      st_reg.pin0     <= 1'b1;
    end else begin
      st_reg <= st_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // fifo storage, no reset needed: reads are gated by the count
  always_ff @(posedge CLOCK_I) begin
    if (push) begin
      fifo_mem[st_reg.wr] <= RX_FRAME_I;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign ACK_O             = st_reg.ack;
  assign DAT_O             = {24'h000000, st_reg.dat};
  assign RESET_MODE_O      = st_reg.halt;
  assign ABORT_O           = st_reg.abort;
  assign SLEEPING_O        = (st_reg.pwr == PWR_SLEEP);
  assign WAKEUP_O          = st_reg.wake;
  assign FILTER_SINGLE_O   = st_reg.filt;
  assign SELF_CHECK_O      = st_reg.self_chk;
  assign PASSIVE_MONITOR_O = st_reg.passive;
  assign TX_SUCCESS_O      = st_reg.tx_ok;
  assign MSG_COUNT_O       = st_reg.count;
  assign TX_PIN_FIRST_O    = st_reg.pin0;
  assign TX_PIN_SECOND_O   = st_reg.pin1;

endmodule

// ==== cmr_top_test.sv ====
// Purpose: self-checking bench for cmr_top
// Assumes: Wishbone classic master, byte registers in the low lane
// Notes:   fifo depth two makes the full case short
`timescale 1ns/1ps
module cmr_top_test;
  import cmr_pkg::*;
  localparam int RX_DEPTH = 2;
  logic CLOCK_I, RST_N_I, CYC_I, STB_I, WE_I, ACK_O, IRQ_PENDING_I, BUS_IDLE_I;
  logic RX_VALID_I, RX_READY_O, TX_BIT_I, ACK_SLOT_I, BIT_START_I, TQ_TICK_I;
  logic TX_DONE_I, ACK_SEEN_I, RESET_MODE_O, ABORT_O, SLEEPING_O, WAKEUP_O;
  logic FILTER_SINGLE_O, SELF_CHECK_O, PASSIVE_MONITOR_O, TX_SUCCESS_O;
  logic TX_PIN_FIRST_O, TX_PIN_SECOND_O, run, nb, ns, nt, e_first, e_clk;
  logic [6:2]  ADR_I;
  logic [3:0]  SEL_I;
  logic [31:0] DAT_I, DAT_O;
  logic [4:0]  MSG_COUNT_O;
  cmr_frame_t  RX_FRAME_I, fs, fe;
  int fails, checks, aborts, wakes;
  cmr_top #(.RX_DEPTH(RX_DEPTH)) u_dut (.*);
  cmr_bus_model u_bus (.clk_i(CLOCK_I), .rst_n_i(RST_N_I), .run_i(run), .tx_bit_o(TX_BIT_I),
    .bit_start_o(BIT_START_I), .tq_tick_o(TQ_TICK_I), .ack_slot_o(ACK_SLOT_I));
  initial begin
    CLOCK_I = 1'b0;
    forever #20 CLOCK_I = ~CLOCK_I;
  end
  // sample stream mid-cycle, then model the pins one edge on
  always @(negedge CLOCK_I) begin
    nb = TX_BIT_I; ns = BIT_START_I; nt = TQ_TICK_I;
    if (ABORT_O === 1'b1) aborts++;
    if (WAKEUP_O === 1'b1) wakes++;
  end
  always @(posedge CLOCK_I) begin
    e_first <= nb;
    e_clk <= ns ? 1'b1 : (nt ? 1'b0 : e_clk);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic g, input logic e);
    chk({31'h0, g}, {31'h0, e});
  endtask
  task automatic stop_test();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one classic cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [4:0] a, input logic [7:0] d,
                    output logic [31:0] q);
    @(posedge CLOCK_I);
    CYC_I <= 1'b1; STB_I <= 1'b1; WE_I <= w; ADR_I <= a; DAT_I <= {24'h0, d};
    // ack and read data are taken at the very edge where ack is high
    do @(posedge CLOCK_I); while (ACK_O !== 1'b1);
    q = DAT_O;
    CYC_I <= 1'b0; STB_I <= 1'b0; WE_I <= 1'b0;
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [4:0] a, input logic [7:0] e);
    logic [31:0] q;
    wb(1'b0, a, 8'h0, q);
    chk(q, {24'h0, e});
  endtask
  task automatic push(input cmr_frame_t f);
    @(posedge CLOCK_I);
    RX_VALID_I <= 1'b1; RX_FRAME_I <= f;
    // the frame is taken at the edge where ready is high
    do @(posedge CLOCK_I); while (RX_READY_O !== 1'b1);
    RX_VALID_I <= 1'b0; RX_FRAME_I <= ~f; // stale bytes must never be taken
  endtask
  task automatic win(input cmr_frame_t f, input logic ext);
    for (int i = 0; i < WIN_BYTES; i++) rd(IDX_WIN_LO + 5'(i), (ext || i < 11) ? f[i] : 8'h00);
  endtask
  task automatic pins(input logic [1:0] m);
    repeat (24) begin
      @(negedge CLOCK_I);
      chk1(TX_PIN_FIRST_O, m[1] ? e_first : 1'b1);
      chk1(TX_PIN_SECOND_O, m[1] && (m[0] ? e_clk : !e_first));
    end
  endtask
  task automatic done(input logic ack, input logic e);
    @(posedge CLOCK_I);
    TX_DONE_I <= 1'b1; ACK_SEEN_I <= ack;
    @(posedge CLOCK_I);
    TX_DONE_I <= 1'b0; ACK_SEEN_I <= !ack;
    @(negedge CLOCK_I);
    chk1(TX_SUCCESS_O, e);
  endtask
  task automatic t_regs();
    rd(IDX_MODE, MODE_RESET);
    rd(IDX_OCR, 8'h02);
    rd(IDX_WIN_LO, 8'h00);
    rd(5'h1e, 8'h00);
    wr(IDX_MODE, 8'hff);
    rd(IDX_MODE, 8'h0f);
    chk1(SLEEPING_O, 1'b0);
    wr(IDX_OCR, 8'hff);
    rd(IDX_OCR, 8'h03);
    wr(IDX_MODE, 8'h00);
    wr(IDX_OCR, 8'h02);
    rd(IDX_OCR, 8'h03);
    $display("regs test done");
  endtask
  task automatic t_drive();
    logic [1:0] m [4] = '{2'h3, 2'h2, 2'h0, 2'h1};
    run <= 1'b1;
    foreach (m[k]) begin
      wr(IDX_MODE, 8'h01);
      wr(IDX_OCR, {6'h00, m[k]});
      wr(IDX_MODE, 8'h00);
      repeat (9) @(posedge CLOCK_I);
      pins(m[k]);
    end
    wr(IDX_MODE, 8'h01);
    wr(IDX_OCR, 8'h02);
    wr(IDX_MODE, 8'h00);
    run <= 1'b0;
    $display("driver test done");
  endtask
  task automatic t_rx();
    int a0;
    push(fs);
    push(fe);
    rd(IDX_COUNT, 8'h02);
    chk1(RX_READY_O, 1'b0);
    win(fs, 1'b0);
    wr(IDX_WIN_LO, 8'hff);
    rd(IDX_WIN_LO, fs[0]);
    wr(IDX_CMD, 8'h04);
    rd(IDX_COUNT, 8'h01);
    win(fe, 1'b1);
    a0 = aborts;
    wr(IDX_MODE, 8'h01);
    rd(IDX_COUNT, 8'h00);
    chk1(aborts > a0, 1'b1);
    wr(IDX_MODE, 8'h00);
    @(negedge CLOCK_I);
    chk1(RESET_MODE_O, 1'b0);
    $display("receive test done");
  endtask
  task automatic t_sleep();
    int w0;
    w0 = wakes;
    IRQ_PENDING_I <= 1'b1;
    wr(IDX_MODE, 8'h10);
    repeat (2) @(negedge CLOCK_I);
    chk1(SLEEPING_O, 1'b0);
    chk1(wakes > w0, 1'b1);
    @(posedge CLOCK_I);
    IRQ_PENDING_I <= 1'b0;
    wr(IDX_MODE, 8'h10);
    repeat (2) @(negedge CLOCK_I);
    chk1(SLEEPING_O, 1'b1);
    wr(IDX_MODE, 8'h00);
    repeat (2) @(negedge CLOCK_I);
    chk1(SLEEPING_O, 1'b0);
    $display("sleep test done");
  endtask
  task automatic t_tx();
    wr(IDX_MODE, 8'h0e);
    @(negedge CLOCK_I);
    chk1(FILTER_SINGLE_O, 1'b1);
    chk1(PASSIVE_MONITOR_O, 1'b1);
    done(1'b0, 1'b1);
    @(posedge CLOCK_I);
    run <= 1'b1;
    repeat (40) @(posedge CLOCK_I);
    run <= 1'b0;
    wr(IDX_MODE, 8'h00);
    @(negedge CLOCK_I);
    chk1(FILTER_SINGLE_O, 1'b0);
    done(1'b0, 1'b0);
    done(1'b1, 1'b1);
    $display("transmit test done");
  endtask
  initial begin
    {CYC_I, STB_I, WE_I, IRQ_PENDING_I, RX_VALID_I, TX_DONE_I, ACK_SEEN_I, run} = '0;
    BUS_IDLE_I = 1'b1; SEL_I = 4'h1; ADR_I = '0; DAT_I = '0; RX_FRAME_I = '0;
    RST_N_I = 1'b0; fails = 0; checks = 0; aborts = 0; wakes = 0; e_clk = 1'b0;
    for (int i = 0; i < WIN_BYTES; i++) begin
      fs[i] = 8'h30 + 8'(i);
      fe[i] = 8'h50 + 8'(i);
    end
    fs[0] = 8'h08;
    fe[0] = 8'h88;
    repeat (6) @(posedge CLOCK_I);
    RST_N_I <= 1'b1;
    t_regs();
    t_drive();
    t_rx();
    t_sleep();
    t_tx();
    stop_test();
  end
  // cut a hang short well past the expected run length
  initial begin
    repeat (20000) @(posedge CLOCK_I);
    fails++;
    stop_test();
  end
endmodule
bind cmr_top cmr_monitor #(.RX_DEPTH(RX_DEPTH)) u_mon (.*);
